// ===== core/wor_decode.sv
/*
  Decodes the stored option byte into the settings used by the rest of the
  device. Pure combinational; the caller registers the outputs.
*/
`timescale 1ns/1ns
module wor_decode (
  input wire logic [7:0] option_byte,
  output wor_pkg::wor_opts_t opts
);

  // ----------------------------------------
  // Option decode
  // ----------------------------------------
  // Power-off overrides the monitor's other controls
  always_comb begin
    opts.watchdog_period = option_byte[wor_pkg::WOR_WATCHDOG_RATE_SELECT_BIT] ?
      wor_pkg::WOR_WDOG_SHORT : wor_pkg::WOR_WDOG_LONG;
    opts.watchdog_enable = !option_byte[wor_pkg::WOR_WATCHDOG_DISABLE_BIT];
    opts.monitor_powered = !option_byte[wor_pkg::WOR_MONITOR_POWER_OFF_BIT];
    opts.monitor_reset_enable = !(option_byte[wor_pkg::WOR_MONITOR_RESET_DISABLE_BIT]
      && opts.monitor_powered);
    opts.monitor_in_stop = option_byte[wor_pkg::WOR_MONITOR_IN_STOP_ENABLE_BIT]
      && opts.monitor_powered;
    opts.stop_legal = option_byte[wor_pkg::WOR_STOP_ENABLE_BIT];
    opts.recovery_cycles = option_byte[wor_pkg::WOR_SHORT_RECOVERY_SELECT_BIT] ?
      wor_pkg::WOR_RECOVER_SHORT : wor_pkg::WOR_RECOVER_LONG;
  end

endmodule

// ===== core/wor_pkg.sv
/*
  Package for the write-once option register: register map, field positions,
  reset values, timing counts and the carriers shared by the block's files.
  Assumes a 250 MHz pclk and APB access with 32-bit data.
*/
package wor_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] WOR_OPTION_SETUP_ADDR = 12'h000;
  localparam logic [11:0] WOR_STATUS_ADDR = 12'h004;
  localparam logic [11:0] WOR_STOP_CTRL_ADDR = 12'h008;

  // ----------------------------------------
  // Option field positions
  // ----------------------------------------
  localparam int WOR_WATCHDOG_RATE_SELECT_BIT = 7;
  localparam int WOR_MONITOR_IN_STOP_ENABLE_BIT = 6;
  localparam int WOR_MONITOR_RESET_DISABLE_BIT = 5;
  localparam int WOR_MONITOR_POWER_OFF_BIT = 4;
  localparam int WOR_SHORT_RECOVERY_SELECT_BIT = 3;
  localparam int WOR_STOP_ENABLE_BIT = 1;
  localparam int WOR_WATCHDOG_DISABLE_BIT = 0;
  localparam logic [7:0] WOR_OPTION_RESET = 8'h00;
  localparam logic [7:0] WOR_OPTION_MASK = 8'hfb;

  // Stop control word bits
  localparam int WOR_STOP_REQ_BIT = 0;
  localparam int WOR_STOP_WAKE_BIT = 1;

  // ----------------------------------------
  // Timing in reference clock cycles
  // ----------------------------------------
  localparam logic [17:0] WOR_WDOG_SHORT = 18'((1 << 13) - (1 << 4));
  localparam logic [17:0] WOR_WDOG_LONG = 18'((1 << 18) - (1 << 4));
  localparam logic [12:0] WOR_RECOVER_SHORT = 13'd32;
  localparam logic [12:0] WOR_RECOVER_LONG = 13'd4096;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [17:0] watchdog_period;
    logic watchdog_enable;
    logic monitor_powered;
    logic monitor_reset_enable;
    logic monitor_in_stop;
    logic stop_legal;
    logic [12:0] recovery_cycles;
  } wor_opts_t;

  typedef enum logic [2:0] {
    WOR_RUN = 3'b001,
    WOR_STOPPED = 3'b010,
    WOR_RECOVER = 3'b100
  } wor_stop_state_t;

endpackage

// ===== core/wor_top.sv
/*
  Write-once option register with APB slave, option outputs and a small
  stop-mode sequencer that applies the stop enable and recovery delay.
  Assumes pclk stands for the reference oscillator clock and that a
  stop request arrives from the core as a software write.
  Assumes presetn gathers every reset cause of the device, so any reset
  re-arms the one option write. Assumes an APB master that keeps its
  request up through the access cycle, since pready is a one-cycle pulse.
  The watchdog and supply monitor themselves live outside this block.
*/
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module wor_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [17:0] watchdog_period,
  output logic watchdog_enable,
  output logic monitor_powered,
  output logic monitor_reset_enable,
  output logic monitor_in_stop,
  output logic stopped,
  output logic illegal_opcode
);

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  // 0x000 option setup, read/write once per reset:
  //   bit 7 watchdog_rate_select: 1 short timeout, 0 long timeout
  //   bit 6 monitor_in_stop_enable: keeps the supply monitor alive in stop
  //   bit 5 monitor_reset_disable: masks the supply monitor's reset request
  //   bit 4 monitor_power_off: removes supply monitor power, masks bits 6 and 5
  //   bit 3 short_recovery_select: 1 short stop recovery, 0 long
  //   bit 2 reserved, reads 0 and ignores writes
  //   bit 1 stop enable: without it a stop request is an illegal opcode
  //   bit 0 watchdog_disable: 1 turns the watchdog module off
  //   Upper bits read 0 and are dropped on write.
  // 0x004 status, read only in effect:
  //   bit 0 option written since reset
  //   bits 3:1 stop state, one-hot: run, stopped, recovering
  //   Writes are answered without error and change nothing.
  // 0x008 stop control, write only, reads 0:
  //   bit 0 stop request, acted on only from run
  //   bit 1 wake request, acted on only from stop
  // Any other address answers with pslverr; a read of one also zeroes the held read data, other state is left alone.
  // Software must leave short recovery clear when a crystal drives the
  // reference clock; the block cannot tell and does not check.

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] option;
    logic written;
    wor_pkg::wor_opts_t opts;
    wor_pkg::wor_stop_state_t st;
    logic [12:0] count;
    logic illegal;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic stopped;
  } wor_state_t;

  wor_state_t s_q;
  wor_state_t s_d;
  wor_pkg::wor_opts_t dec;

  // Decode of the next option value, so outputs track the write by one cycle
  // The decode reads s_d.option only, never s_d.opts, so there is no real loop
  wor_decode u_decode (
    .option_byte(s_d.option),
    .opts(dec)
  );

  logic setup;
  logic wr;
  logic rd;
  assign setup = psel && !penable;
  assign wr = setup && pwrite;
  assign rd = setup && !pwrite;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Answer takes one access cycle: setup is decoded, pready rises with access
  always_comb begin
    s_d = s_q;
    s_d.ready = setup;
    s_d.err = 1'b0;
    s_d.illegal = 1'b0;
    // Register writes, decoded in the setup cycle
    if (wr) begin
      case (paddr)
        wor_pkg::WOR_OPTION_SETUP_ADDR: begin
          // Only the first write lands; later ones are silently dropped
          if (!s_q.written) begin
            s_d.option = pwdata[7:0] & wor_pkg::WOR_OPTION_MASK;
            s_d.written = 1'b1;
          end
        end
        wor_pkg::WOR_STOP_CTRL_ADDR: begin
          // A stop request only acts from run; a wake only acts from stop
          if (pwdata[wor_pkg::WOR_STOP_REQ_BIT] && s_q.st == wor_pkg::WOR_RUN) begin
            if (s_q.opts.stop_legal) begin
              s_d.st = wor_pkg::WOR_STOPPED;
            end else begin
              s_d.illegal = 1'b1;
            end
          end
          if (pwdata[wor_pkg::WOR_STOP_WAKE_BIT] && s_q.st == wor_pkg::WOR_STOPPED) begin
            s_d.st = wor_pkg::WOR_RECOVER;
            s_d.count = s_q.opts.recovery_cycles - 13'd1;
          end
        end
        wor_pkg::WOR_STATUS_ADDR: begin
          s_d.err = 1'b0;
        end
        default: begin
          s_d.err = 1'b1;
        end
      endcase
    end
    // Register reads; the data is held until the next read
    if (rd) begin
      case (paddr)
        wor_pkg::WOR_OPTION_SETUP_ADDR: s_d.rdata = {24'h000000, s_q.option};
        wor_pkg::WOR_STATUS_ADDR: begin
          s_d.rdata = {28'h0000000, s_q.st, s_q.written};
        end
        wor_pkg::WOR_STOP_CTRL_ADDR: s_d.rdata = 32'h00000000;
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.err = 1'b1;
        end
      endcase
    end
    // Recovery countdown, one cycle per reference clock
    case (s_q.st)
      wor_pkg::WOR_RUN: begin
      end
      wor_pkg::WOR_STOPPED: begin
      end
      wor_pkg::WOR_RECOVER: begin
        if (s_q.count == 13'd0) begin
          s_d.st = wor_pkg::WOR_RUN;
        end else begin
          s_d.count = s_q.count - 13'd1;
        end
      end
      default: s_d.st = wor_pkg::WOR_RUN;
    endcase
    s_d.opts = dec;
    // Stopped is registered from the next state so the pin keeps step with st
    s_d.stopped = (s_d.st != wor_pkg::WOR_RUN);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Any reset restores defaults and re-arms the one write
  // Defaults equal the decode of an all-zero option byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.option <= wor_pkg::WOR_OPTION_RESET;
      s_q.written <= 1'b0;
      s_q.opts.watchdog_period <= wor_pkg::WOR_WDOG_LONG;
      s_q.opts.watchdog_enable <= 1'b1;
      s_q.opts.monitor_powered <= 1'b1;
      s_q.opts.monitor_reset_enable <= 1'b1;
      s_q.opts.monitor_in_stop <= 1'b0;
      s_q.opts.stop_legal <= 1'b0;
      s_q.opts.recovery_cycles <= wor_pkg::WOR_RECOVER_LONG;
      s_q.st <= wor_pkg::WOR_RUN;
      s_q.count <= 13'h0000;
      s_q.illegal <= 1'b0;
      s_q.rdata <= 32'h00000000;
      s_q.ready <= 1'b0;
      s_q.err <= 1'b0;
      s_q.stopped <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------
  // APB answer, one cycle wide apart from the held read data
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;

  // Option settings, steady between resets once the one write has landed
  assign watchdog_period = s_q.opts.watchdog_period;
  assign watchdog_enable = s_q.opts.watchdog_enable;
  assign monitor_powered = s_q.opts.monitor_powered;
  assign monitor_reset_enable = s_q.opts.monitor_reset_enable;
  assign monitor_in_stop = s_q.opts.monitor_in_stop;

  // Stop sequencer; stopped has its own flop so no compare sits on the pin
  assign stopped = s_q.stopped;
  assign illegal_opcode = s_q.illegal;

endmodule

// ===== test/wor_top_assertions.sv
/*
  Port-level checker for the write-once option register.
  Assumes it is bound to wor_top and sees only that module's ports.
*/
`timescale 1ns/1ns
module wor_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [17:0] watchdog_period,
  input wire logic watchdog_enable,
  input wire logic monitor_powered,
  input wire logic monitor_reset_enable,
  input wire logic monitor_in_stop,
  input wire logic stopped,
  input wire logic illegal_opcode
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  bus_answer_a: assert property (psel && !penable |=> pready)
    else $error("setup cycle got no answer");
  answer_place_a: assert property (pready |-> psel && penable)
    else $error("answer outside an access cycle");
  unmapped_err_a: assert property (psel && !penable && paddr[11:4] != 0 |=> pslverr)
    else $error("unmapped access without error");
  // Settings may only move on an option write, never on their own
  opts_cause_a: assert property ($changed({watchdog_period, watchdog_enable,
    monitor_powered, monitor_reset_enable, monitor_in_stop})
    |-> $past(psel && !penable && pwrite && paddr == 12'h000))
    else $error("settings moved without an option write");
  period_set_a: assert property (watchdog_period == wor_pkg::WOR_WDOG_SHORT ||
    watchdog_period == wor_pkg::WOR_WDOG_LONG) else $error("bad watchdog period");
  stop_power_a: assert property (monitor_in_stop |-> monitor_powered)
    else $error("monitor in stop while unpowered");
  reset_block_a: assert property (!monitor_reset_enable |-> monitor_powered)
    else $error("monitor reset blocked while unpowered");
  illegal_pulse_a: assert property (illegal_opcode |=> !illegal_opcode)
    else $error("illegal flag longer than one cycle");
  illegal_run_a: assert property (illegal_opcode |-> !stopped)
    else $error("stopped on an illegal stop");
endmodule

bind wor_top wor_top_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .watchdog_period, .watchdog_enable, .monitor_powered,
  .monitor_reset_enable, .monitor_in_stop, .stopped, .illegal_opcode);

// ===== test/wor_top_tb.sv
/*
  Self-checking bench for the write-once option register.
  Assumes the APB slave answers in the access cycle and pclk runs at 250 MHz.
*/
`timescale 1ns/1ns
module wor_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, watchdog_enable, monitor_powered, stopped;
  logic monitor_reset_enable, monitor_in_stop, illegal_opcode;
  logic [17:0] watchdog_period;
  int fail_count = 0;
  int n_tests = 0;
  int n_ill = 0;
  int n;

  always #2 pclk = ~pclk;

  wor_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .watchdog_period, .watchdog_enable, .monitor_powered,
    .monitor_reset_enable, .monitor_in_stop, .stopped, .illegal_opcode);

  // Counts illegal pulses; a one-cycle flag is easy to miss by polling
  always @(posedge pclk) if (illegal_opcode === 1'b1) n_ill++;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] opts();
    return {10'h0, watchdog_period, watchdog_enable, monitor_powered,
      monitor_reset_enable, monitor_in_stop};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; bounded wait on pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) chk(32'h0, 32'h1);
    @(posedge pclk);
  endtask

  task rst();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task wake(output int c);
    apb(1'b1, wor_pkg::WOR_STOP_CTRL_ADDR, 32'h2);
    c = 0;
    while (stopped === 1'b1 && c < 5000) begin
      @(posedge pclk);
      c++;
    end
  endtask

  task close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard: the tests need well under 10000 cycles
  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  initial begin
    rst();
    chk(opts(), {10'h0, wor_pkg::WOR_WDOG_LONG, 4'b1110});
    apb(1'b0, wor_pkg::WOR_OPTION_SETUP_ADDR, 32'h0);
    chk(rdata, 32'h0);
    apb(1'b1, wor_pkg::WOR_OPTION_SETUP_ADDR, 32'hff);
    // Power-off wins over the monitor's stop and reset-disable bits
    chk(opts(), {10'h0, wor_pkg::WOR_WDOG_SHORT, 4'b0010});
    apb(1'b0, wor_pkg::WOR_STATUS_ADDR, 32'h0);
    chk(rdata, 32'h3);
    apb(1'b1, wor_pkg::WOR_OPTION_SETUP_ADDR, 32'h0);
    apb(1'b0, wor_pkg::WOR_OPTION_SETUP_ADDR, 32'h0);
    chk(rdata, 32'hfb);
    chk(opts(), {10'h0, wor_pkg::WOR_WDOG_SHORT, 4'b0010});
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b1, wor_pkg::WOR_STOP_CTRL_ADDR, 32'h1);
    chk({31'h0, stopped}, 32'h1);
    apb(1'b0, wor_pkg::WOR_STATUS_ADDR, 32'h0);
    chk(rdata, 32'h5);
    wake(n);
    chk({31'h0, n inside {[28:34]}}, 32'h1);
    // Second reset re-arms the register; power off masks the stop option
    rst();
    chk(opts(), {10'h0, wor_pkg::WOR_WDOG_LONG, 4'b1110});
    apb(1'b1, wor_pkg::WOR_OPTION_SETUP_ADDR, 32'h50);
    chk(opts(), {10'h0, wor_pkg::WOR_WDOG_LONG, 4'b1010});
    n_ill = 0;
    apb(1'b1, wor_pkg::WOR_STOP_CTRL_ADDR, 32'h1);
    repeat (2) @(posedge pclk);
    chk(n_ill, 32'h1);
    chk({31'h0, stopped}, 32'h0);
    // Crystal-style setup: short recovery left clear, monitor powered
    rst();
    apb(1'b1, wor_pkg::WOR_OPTION_SETUP_ADDR, 32'h62);
    chk(opts(), {10'h0, wor_pkg::WOR_WDOG_LONG, 4'b1101});
    apb(1'b1, wor_pkg::WOR_STOP_CTRL_ADDR, 32'h1);
    wake(n);
    chk({31'h0, n inside {[4092:4098]}}, 32'h1);
    close_out();
  end
endmodule
